/* rtl/phy_basic_mode_control_regs.sv */
// The APB register port is this design's own decision.
`include "phy_regs_defs.svh"

// Overview of operation
// - writing reset bit resets port, relatches straps; reads one until done
// - loopback bit returns mii transmit data onto mii receive lines
// - with negotiation off, speed bit picks 100 (one) or 10 (zero); strap default
// - negotiation enable set ignores forced speed and duplex bits
// - power-down bit ORed with active-low pin; pin assertion sets the bit
// - powered down, only register access keeps working
// - isolate bit disconnects the mii; management access still works
// - strap-defaulted fields reload from strap pins after every reset
// - latched-high/low fields hold their event state until read
// - clear-on-read fields return value on read, then clear
// - fixed read-only fields always read their default, ignore writes
// - tracking flags follow their event without software action
// - restart bit restarts negotiation only when enabled, clears once started
// - with negotiation off, duplex bit picks full (one) or half; strap default
// - collision test raises collision after tx enable, drops within 4 bit times
module phy_basic_mode_control_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic strap_speed_100,
    input wire logic strap_autoneg_en,
    input wire logic strap_full_duplex,
    input wire logic interrupt_powerdown_pin_n,
    input wire logic [3:0] mii_txd,
    input wire logic mii_tx_en,
    output logic [3:0] mii_rxd,
    output logic mii_rx_dv,
    output logic mii_col,
    output logic mii_out_oe,
    input wire logic [3:0] phy_rxd,
    input wire logic phy_rx_dv,
    input wire logic phy_col,
    output logic [3:0] core_txd,
    output logic core_tx_en,
    output logic core_soft_reset,
    output logic core_power_down,
    input wire logic an_speed_100,
    input wire logic an_full_duplex,
    input wire logic an_started,
    output logic an_enable,
    output logic an_restart,
    output logic link_speed_100,
    output logic link_full_duplex,
    input wire logic link_ok,
    input wire logic fault_event,
    input wire logic energy_present,
    input wire logic false_carrier_event,
    input wire logic [15:0] diag_general,
    input wire logic [15:0] diag_two,
    input wire logic [15:0] diag_three
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [8:0] pin_s1_reg;
    logic [8:0] pin_s2_reg;
    logic strap_speed_s, strap_an_s, strap_dup_s, pwdn_n_s, tx_en_s;
    logic [3:0] txd_s;

    // mii tx bits come from the mac clock; sampled twice like any pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_reg <= 9'h100;
            pin_s2_reg <= 9'h100;
        end else begin
            pin_s1_reg <= {interrupt_powerdown_pin_n, strap_speed_100, strap_autoneg_en,
                           strap_full_duplex, mii_tx_en, mii_txd};
            pin_s2_reg <= pin_s1_reg;
        end
    end
    assign {pwdn_n_s, strap_speed_s, strap_an_s, strap_dup_s, tx_en_s, txd_s} = pin_s2_reg;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    logic [9:0] idx;
    logic setup, access, wr_bmc, rd_setup, mapped;
    assign idx = paddr[11:2];
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign mapped = (idx == `BMC_IDX) || (idx == `EVT_IDX) || (idx == `CDG_IDX) ||
                    (idx == `LCD2_IDX) || (idx == `LCD3_IDX);
    assign rd_setup = setup & ~pwrite & mapped;
    assign pready = 1'b1; // zero wait states
    assign pslverr = access & ~mapped;

    // ----------------------------------------------------------------
    // reset sequencer
    // ----------------------------------------------------------------
    phy_regs_pkg::ctl_state_t state_reg;
    logic [7:0] cnt_reg;
    logic running, load_now;
    assign running = (state_reg == phy_regs_pkg::ST_RUN);
    assign wr_bmc = access & pwrite & (idx == `BMC_IDX) & running;
    assign load_now = (state_reg == phy_regs_pkg::ST_LOAD) && (cnt_reg == 8'h00);

    // after hardware reset wait for the strap synchroniser to fill
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= phy_regs_pkg::ST_LOAD;
            cnt_reg <= 8'(`STRAP_SETTLE_CYC - 1);
        end else begin
            case (state_reg)
                phy_regs_pkg::ST_LOAD: begin
                    if (cnt_reg == 8'h00) begin
                        state_reg <= phy_regs_pkg::ST_RUN;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                phy_regs_pkg::ST_RUN: begin
                    if (wr_bmc && pwdata[`BMC_RESET_BIT]) begin
                        state_reg <= phy_regs_pkg::ST_SRESET;
                        cnt_reg <= 8'(`SRESET_CYC - 1);
                    end
                end
                phy_regs_pkg::ST_SRESET: begin
                    if (cnt_reg == 8'h00) begin
                        state_reg <= phy_regs_pkg::ST_LOAD;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                default: begin
                    state_reg <= phy_regs_pkg::ST_LOAD;
                    cnt_reg <= 8'h00;
                end
            endcase
        end
    end
    assign core_soft_reset = ~running;

    // ----------------------------------------------------------------
    // control bits
    // ----------------------------------------------------------------
    logic loop_reg, speed_reg, an_en_reg, pd_reg, iso_reg, restart_reg;
    logic duplex_reg, coltest_reg;

    // plain control bits return to zero while a soft reset runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_reg <= 1'b0;
            iso_reg <= 1'b0;
            coltest_reg <= 1'b0;
        end else if (state_reg == phy_regs_pkg::ST_SRESET) begin
            loop_reg <= 1'b0;
            iso_reg <= 1'b0;
            coltest_reg <= 1'b0;
        end else if (wr_bmc) begin
            loop_reg <= pwdata[`BMC_LOOP_BIT];
            iso_reg <= pwdata[`BMC_ISO_BIT];
            coltest_reg <= pwdata[`BMC_COLTEST_BIT];
        end
    end

    // strap-defaulted bits are relatched on every pass through load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_reg <= 1'b1;
            an_en_reg <= 1'b1;
            duplex_reg <= 1'b1;
        end else if (load_now) begin
            speed_reg <= strap_speed_s;
            an_en_reg <= strap_an_s;
            duplex_reg <= strap_dup_s;
        end else if (wr_bmc) begin
            speed_reg <= pwdata[`BMC_SPEED_BIT];
            an_en_reg <= pwdata[`BMC_AN_EN_BIT];
            duplex_reg <= pwdata[`BMC_DUPLEX_BIT];
        end
    end

    // the pin holds the bit set; software cannot clear it while low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_reg <= 1'b0;
        end else if (!pwdn_n_s) begin
            pd_reg <= 1'b1;
        end else if (state_reg == phy_regs_pkg::ST_SRESET) begin
            pd_reg <= 1'b0;
        end else if (wr_bmc) begin
            pd_reg <= pwdata[`BMC_PDOWN_BIT];
        end
    end
    assign core_power_down = pd_reg | ~pwdn_n_s;

    // restart only taken with negotiation enabled in the same write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_reg <= 1'b0;
        end else if (state_reg == phy_regs_pkg::ST_SRESET) begin
            restart_reg <= 1'b0;
        end else if (wr_bmc && pwdata[`BMC_RESTART_BIT] && pwdata[`BMC_AN_EN_BIT]) begin
            restart_reg <= 1'b1;
        end else if (an_started) begin
            restart_reg <= 1'b0;
        end
    end
    assign an_restart = restart_reg;
    assign an_enable = an_en_reg;

    // effective mode: negotiated result wins while negotiation is on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_speed_100 <= 1'b1;
            link_full_duplex <= 1'b1;
        end else begin
            link_speed_100 <= an_en_reg ? an_speed_100 : speed_reg;
            link_full_duplex <= an_en_reg ? an_full_duplex : duplex_reg;
        end
    end

    // ----------------------------------------------------------------
    // mii data path
    // ----------------------------------------------------------------
    logic active;
    assign active = ~core_power_down & ~iso_reg & running;

    // outputs rest at zero when isolated or powered down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mii_rxd <= 4'h0;
            mii_rx_dv <= 1'b0;
            mii_col <= 1'b0;
            core_txd <= 4'h0;
            core_tx_en <= 1'b0;
        end else if (!active) begin
            mii_rxd <= 4'h0;
            mii_rx_dv <= 1'b0;
            mii_col <= 1'b0;
            core_txd <= 4'h0;
            core_tx_en <= 1'b0;
        end else begin
            mii_rxd <= loop_reg ? txd_s : phy_rxd;
            mii_rx_dv <= loop_reg ? tx_en_s : phy_rx_dv;
            mii_col <= coltest_reg ? tx_en_s : (phy_col & ~loop_reg);
            core_txd <= txd_s;
            core_tx_en <= tx_en_s & ~loop_reg; // looped frames stay off the wire
        end
    end
    assign mii_out_oe = ~iso_reg;

    // ----------------------------------------------------------------
    // status fields
    // ----------------------------------------------------------------
    logic evt_rd, st_en, st_link, st_fault, st_energy;
    logic [`EVT_CNT_W-1:0] st_cnt;
    assign evt_rd = rd_setup & (idx == `EVT_IDX);
    assign st_en = ~core_power_down;

    status_flag_cell #(.MODE(phy_regs_pkg::FLAG_LL), .WIDTH(1)) link_cell (
        .pclk(pclk), .presetn(presetn), .enable(st_en), .event_in(link_ok),
        .read_clear(evt_rd), .value(st_link));
    status_flag_cell #(.MODE(phy_regs_pkg::FLAG_LH), .WIDTH(1)) fault_cell (
        .pclk(pclk), .presetn(presetn), .enable(st_en), .event_in(fault_event),
        .read_clear(evt_rd), .value(st_fault));
    status_flag_cell #(.MODE(phy_regs_pkg::FLAG_SC), .WIDTH(1)) energy_cell (
        .pclk(pclk), .presetn(presetn), .enable(st_en), .event_in(energy_present),
        .read_clear(evt_rd), .value(st_energy));
    status_flag_cell #(.MODE(phy_regs_pkg::FLAG_COR), .WIDTH(`EVT_CNT_W)) carrier_cell (
        .pclk(pclk), .presetn(presetn), .enable(st_en), .event_in(false_carrier_event),
        .read_clear(evt_rd), .value(st_cnt));

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [15:0] rd_mux;

    // reserved bits read zero; the fixed capability bit ignores writes
    always_comb begin
        rd_mux = 16'h0000;
        case (idx)
            `BMC_IDX: begin
                rd_mux[`BMC_RESET_BIT] = ~running;
                rd_mux[`BMC_LOOP_BIT] = loop_reg;
                rd_mux[`BMC_SPEED_BIT] = speed_reg;
                rd_mux[`BMC_AN_EN_BIT] = an_en_reg;
                rd_mux[`BMC_PDOWN_BIT] = core_power_down;
                rd_mux[`BMC_ISO_BIT] = iso_reg;
                rd_mux[`BMC_RESTART_BIT] = restart_reg;
                rd_mux[`BMC_DUPLEX_BIT] = duplex_reg;
                rd_mux[`BMC_COLTEST_BIT] = coltest_reg;
            end
            `EVT_IDX: begin
                rd_mux[`EVT_CAP_BIT] = `EVT_CAP_VAL;
                rd_mux[`EVT_CNT_LSB +: `EVT_CNT_W] = st_cnt;
                rd_mux[`EVT_LINK_BIT] = st_link;
                rd_mux[`EVT_FAULT_BIT] = st_fault;
                rd_mux[`EVT_ENERGY_BIT] = st_energy;
            end
            `CDG_IDX: rd_mux = diag_general & `CDG_MASK;
            `LCD2_IDX: rd_mux = diag_two & `LCD2_MASK;
            `LCD3_IDX: rd_mux = diag_three & `LCD3_MASK;
            default: rd_mux = 16'h0000;
        endcase
    end

    // captured in the setup cycle, so clear-on-read clears at that same edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= {16'h0000, rd_mux};
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    localparam int COL_OFF_MAX = `COL_DEASSERT_CYC;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence tx_start_s;
        coltest_reg && active && $rose(tx_en_s);
    endsequence
    sequence tx_stop_s;
        coltest_reg && active && $fell(tx_en_s);
    endsequence

    soft_reset_a: assert property ((wr_bmc && pwdata[`BMC_RESET_BIT]) |=>
        core_soft_reset[*8] ##[100:140] running)
        else $error("soft reset did not run its span");
    loopback_a: assert property ((active && loop_reg) |=> mii_rxd == $past(txd_s))
        else $error("loopback data not returned");
    forced_mode_a: assert property ((!an_en_reg && running) |=>
        link_speed_100 == $past(speed_reg) && link_full_duplex == $past(duplex_reg))
        else $error("forced speed or duplex not applied");
    pin_pdown_a: assert property ((!pwdn_n_s) |=> (pd_reg && core_power_down))
        else $error("power-down pin did not set the bit");
    pdown_quiet_a: assert property (core_power_down |=> !core_tx_en && !mii_rx_dv)
        else $error("data path active while powered down");
    isolate_out_a: assert property (iso_reg |-> !mii_out_oe ##1 !core_tx_en)
        else $error("isolated port still connected");
    strap_load_a: assert property (load_now |=> speed_reg == $past(strap_speed_s) &&
        an_en_reg == $past(strap_an_s) && duplex_reg == $past(strap_dup_s))
        else $error("straps not relatched");
    restart_ign_a: assert property ((wr_bmc && !pwdata[`BMC_AN_EN_BIT] && !restart_reg)
        |=> !restart_reg)
        else $error("restart taken with negotiation disabled");
    cap_fixed_a: assert property ((rd_setup && idx == `EVT_IDX) |=> prdata[`EVT_CAP_BIT])
        else $error("fixed bit read wrong");
    col_on_a: assert property (tx_start_s |-> ##[1:2] mii_col)
        else $error("collision test did not assert");
    col_off_a: assert property (tx_stop_s |-> ##[1:COL_OFF_MAX] !mii_col)
        else $error("collision test did not release");

endmodule

/* include/phy_regs_defs.svh */
`ifndef PHY_REGS_DEFS_SVH
`define PHY_REGS_DEFS_SVH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define BMC_IDX 10'h000
`define EVT_IDX 10'h010
`define CDG_IDX 10'h18a
`define LCD2_IDX 10'h215
`define LCD3_IDX 10'h21d

// ----------------------------------------------------------------
// basic_mode_control field positions
// ----------------------------------------------------------------
`define BMC_RESET_BIT 15
`define BMC_LOOP_BIT 14
`define BMC_SPEED_BIT 13
`define BMC_AN_EN_BIT 12
`define BMC_PDOWN_BIT 11
`define BMC_ISO_BIT 10
`define BMC_RESTART_BIT 9
`define BMC_DUPLEX_BIT 8
`define BMC_COLTEST_BIT 7

// ----------------------------------------------------------------
// event status register layout
// ----------------------------------------------------------------
`define EVT_CAP_BIT 15
`define EVT_CAP_VAL 1'b1
`define EVT_CNT_LSB 4
`define EVT_CNT_W 8
`define EVT_LINK_BIT 2
`define EVT_FAULT_BIT 1
`define EVT_ENERGY_BIT 0

// ----------------------------------------------------------------
// diagnostic result masks, reserved bits read zero
// ----------------------------------------------------------------
`define CDG_MASK 16'hfffc
`define LCD2_MASK 16'h00ff
`define LCD3_MASK 16'h0fff

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define SRESET_NS 1000
`define SRESET_CYC ((`SRESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRAP_SETTLE_CYC 3
`define COL_DEASSERT_BITS 4
`define BIT_NS_100M 10
`define COL_DEASSERT_CYC ((`COL_DEASSERT_BITS * `BIT_NS_100M) / `CLK_PERIOD_NS)

`endif

/* include/phy_regs_pkg.sv */
package phy_regs_pkg;

    // control sequencer, gray along load -> run -> soft reset
    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,
        ST_RUN = 2'b01,
        ST_SRESET = 2'b11
    } ctl_state_t;

    // access behaviour of a status field
    typedef enum logic [1:0] {
        FLAG_LH = 2'b00,
        FLAG_LL = 2'b01,
        FLAG_COR = 2'b10,
        FLAG_SC = 2'b11
    } flag_mode_t;

endpackage

/* rtl/status_flag_cell.sv */
// ----------------------------------------------------------------
// one status field with latched, clear-on-read or tracking behaviour
// ----------------------------------------------------------------
module status_flag_cell #(
    parameter phy_regs_pkg::flag_mode_t MODE = phy_regs_pkg::FLAG_LH,
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic event_in,
    input wire logic read_clear,
    output logic [WIDTH-1:0] value
);

    logic evt_on;
    logic [WIDTH-1:0] value_reg;

    // in power down an event is treated as absent; ll ignores drops
    assign evt_on = (MODE == phy_regs_pkg::FLAG_LL) ? (event_in | ~enable) : (event_in & enable);
    assign value = value_reg;

    // the event wins over a read in the same edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_reg <= '0;
        end else begin
            case (MODE)
                phy_regs_pkg::FLAG_LH: begin
                    if (evt_on) begin
                        value_reg <= WIDTH'(1);
                    end else if (read_clear) begin
                        value_reg <= '0;
                    end
                end
                phy_regs_pkg::FLAG_LL: begin
                    if (!evt_on) begin
                        value_reg <= '0;
                    end else if (read_clear) begin
                        value_reg <= WIDTH'(1);
                    end
                end
                phy_regs_pkg::FLAG_COR: begin
                    if (read_clear) begin
                        value_reg <= WIDTH'(evt_on);
                    end else if (evt_on && !(&value_reg)) begin
                        value_reg <= value_reg + WIDTH'(1);
                    end
                end
                default: begin
                    value_reg <= WIDTH'(evt_on);
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    lh_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (MODE == phy_regs_pkg::FLAG_LH && value_reg[0] && !read_clear) |=> value_reg[0])
        else $error("latched-high flag dropped without a read");
    cor_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (MODE == phy_regs_pkg::FLAG_COR && read_clear && !evt_on) |=> value_reg == '0)
        else $error("clear-on-read field not cleared");
    sc_track_a: assert property (@(posedge pclk) disable iff (!presetn)
        (MODE == phy_regs_pkg::FLAG_SC) |=> value_reg[0] == $past(evt_on))
        else $error("tracking flag does not follow its event");

endmodule

/* bench/mgmt_master.sv */
// ----------------------------------------------------------------
// management controller model: one apb transfer per call
// ----------------------------------------------------------------
module mgmt_master (
    input wire logic pclk,
    input wire logic pready,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    // request held until pready is seen high; the leading edge wait keeps calls apart
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

/* bench/phy_basic_mode_control_regs_tb.sv */
`include "phy_regs_defs.svh"

// ----------------------------------------------------------------
// register bank bench: reads noted in a queue, checked by a monitor
// ----------------------------------------------------------------
module phy_basic_mode_control_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic sp = 1'b0, an = 1'b0, fd = 1'b0, pd_n = 1'b1, tx_en = 1'b0, an_st = 1'b0;
    logic flt = 1'b0, nrg = 1'b0, fcar = 1'b0, lok = 1'b1;
    logic [3:0] txd = 4'h0, rxd, ctxd;
    logic [15:0] dg[3] = '{16'h0000, 16'h0000, 16'h0000};
    logic rx_dv, col, oe, ctx_en, srst, pdown, an_en, an_rs, lsp, lfd;
    logic [32:0] exp_q[$];
    logic [32:0] note;
    int num_errors = 0, num_checks = 0, cyc = 0;
    logic [11:0] dadr[3] = '{{`CDG_IDX, 2'b00}, {`LCD2_IDX, 2'b00}, {`LCD3_IDX, 2'b00}};
    logic [15:0] dmsk[3] = '{`CDG_MASK, `LCD2_MASK, `LCD3_MASK};

    always #4 pclk = ~pclk;

    mgmt_master u_mgmt (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    phy_basic_mode_control_regs u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .strap_speed_100(sp), .strap_autoneg_en(an),
        .strap_full_duplex(fd), .interrupt_powerdown_pin_n(pd_n), .mii_txd(txd),
        .mii_tx_en(tx_en), .mii_rxd(rxd), .mii_rx_dv(rx_dv), .mii_col(col),
        .mii_out_oe(oe), .phy_rxd(4'h5), .phy_rx_dv(1'b0), .phy_col(1'b0),
        .core_txd(ctxd), .core_tx_en(ctx_en), .core_soft_reset(srst),
        .core_power_down(pdown), .an_speed_100(1'b1), .an_full_duplex(1'b0),
        .an_started(an_st), .an_enable(an_en), .an_restart(an_rs), .link_speed_100(lsp),
        .link_full_duplex(lfd), .link_ok(lok), .fault_event(flt), .energy_present(nrg),
        .false_carrier_event(fcar), .diag_general(dg[0]), .diag_two(dg[1]),
        .diag_three(dg[2]));

    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] e);
        num_checks++;
        if (seen !== e) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", name, e, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic err, input logic [15:0] e);
        exp_q.push_back({err, 16'h0000, e});
        u_mgmt.xfer(1'b0, a, 32'h0000_0000);
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        u_mgmt.xfer(1'b1, a, {16'h0000, d});
    endtask

    // monitor: a completed read takes the oldest note
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc > 6000) begin
            num_errors++;
            end_sim();
        end
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            note = exp_q.pop_front();
            check("read", {pslverr, prdata}, note);
        end
    end

    // main sequence; straps random so either default level is exercised
    initial begin
        void'($urandom(32'ha462));
        {sp, an, fd} <= 3'($urandom());
        tick(5);
        presetn <= 1'b1;
        tick(6);
        rd(12'h000, 1'b0, {2'b00, sp, an, 3'b000, fd, 8'h00});
        // an unmapped read flags an error and leaves the last read data standing
        rd(12'h004, 1'b1, {2'b00, sp, an, 3'b000, fd, 8'h00});
        wr(12'h000, 16'h4100);
        txd <= 4'($urandom());
        tx_en <= 1'b1;
        tick(6);
        check("speed", lsp, 1'b0);
        check("duplex", lfd, 1'b1);
        check("loop", {rx_dv, rxd, ctx_en}, {1'b1, txd, 1'b0});
        wr(12'h000, 16'h5100);
        tick(3);
        check("an mode", {lsp, lfd, an_en}, 3'b101);
        // tx enable drops first so that its rise falls inside the collision test
        tx_en <= 1'b0;
        wr(12'h000, 16'h1080);
        tx_en <= 1'b1;
        tick(5);
        check("col on", col, 1'b1);
        check("tx path", {ctx_en, ctxd}, {1'b1, txd});
        tx_en <= 1'b0;
        tick(5);
        check("col off", col, 1'b0);
        wr(12'h000, 16'h1200);
        tick(1);
        check("restart", an_rs, 1'b1);
        an_st <= 1'b1;
        tick(1);
        an_st <= 1'b0;
        tick(2);
        check("restart clr", an_rs, 1'b0);
        // three false carriers, each with a fault pulse, energy held high
        repeat (3) begin
            {fcar, flt} <= 2'b11;
            tick(1);
            {fcar, flt} <= 2'b00;
            tick(1);
        end
        nrg <= 1'b1;
        tick(3);
        rd({`EVT_IDX, 2'b00}, 1'b0, 16'h8033);
        nrg <= 1'b0;
        tick(3);
        wr({`EVT_IDX, 2'b00}, 16'h0000);
        rd({`EVT_IDX, 2'b00}, 1'b0, 16'h8004);
        // a one-cycle link drop must stay latched low until read
        lok <= 1'b0;
        tick(1);
        lok <= 1'b1;
        tick(2);
        rd({`EVT_IDX, 2'b00}, 1'b0, 16'h8000);
        for (int i = 0; i < 3; i++) begin
            dg[i] <= 16'($urandom());
            tick(2);
            rd(dadr[i], 1'b0, dg[i] & dmsk[i]);
        end
        tx_en <= 1'b1;
        wr(12'h000, 16'h1400);
        tick(2);
        check("isolate", {oe, ctx_en, ctxd}, 6'h00);
        pd_n <= 1'b0;
        tick(4);
        check("pdown", pdown, 1'b1);
        rd(12'h000, 1'b0, 16'h1c00);
        pd_n <= 1'b1;
        wr(12'h000, 16'h8000);
        tick(100);
        check("srst busy", srst, 1'b1);
        for (int i = 0; i < 100 && srst !== 1'b0; i++) tick(1);
        tick(2);
        rd(12'h000, 1'b0, {2'b00, sp, an, 3'b000, fd, 8'h00});
        tick(3);
        end_sim();
    end
endmodule
